// file: shared/rcod_consts.svh
// register map, field positions and reset values of the reference clock divider
`ifndef RCOD_CONSTS_SVH
`define RCOD_CONSTS_SVH

// register byte offsets
`define RCOD_OFS_CTRL      8'h00
`define RCOD_OFS_DIV       8'h04
`define RCOD_OFS_TRIM      8'h08

// control low register fields
`define RCOD_BIT_EN        15
`define RCOD_BIT_SIDL      13
`define RCOD_BIT_OUT       12
`define RCOD_BIT_SLP       11
`define RCOD_BIT_SWEN      9
`define RCOD_BIT_ACT       8
`define RCOD_SEL_MSB       3
`define RCOD_SEL_LSB       0

// divisor and trim fields
`define RCOD_DIV_MSB       14
`define RCOD_DIV_LSB       0
`define RCOD_TRIM_MSB      15
`define RCOD_TRIM_LSB      7

// reset values
`define RCOD_RST_SEL       4'h0
`define RCOD_RST_DIV       15'h0000
`define RCOD_RST_TRIM      9'h000

// bus answers
`define RCOD_RESP_OKAY     2'h0
`define RCOD_RESP_SLVERR   2'h2

`endif

// file: shared/rcod_pkg.sv
// types shared by the reference clock divider modules
`default_nettype none
package rcod_pkg;

    typedef enum logic [3:0] {
        RCOD_SRC_SYS   = 4'h0,
        RCOD_SRC_PERIPH = 4'h1,
        RCOD_SRC_PRIMARY = 4'h2,
        RCOD_SRC_FRC   = 4'h3,
        RCOD_SRC_LOW_POWER_RC_OSCILLATOR  = 4'h4,
        RCOD_SRC_SECONDARY_OSCILLATOR  = 4'h5,
        RCOD_SRC_PLL8  = 4'h6,
        RCOD_SRC_EXT   = 4'h8
    } rcod_src_t;

endpackage : rcod_pkg
`default_nettype wire

// file: shared/rcod_div_if.sv
// carrier between source select, divider core and control
`default_nettype none
interface rcod_div_if #(
    parameter int DIV_W  = 15,
    parameter int TRIM_W = 9
);
    logic              base_tick;
    logic              base_level;
    logic              run;
    logic [DIV_W-1:0]  div_val;
    logic [TRIM_W-1:0] trim_val;
    logic              switch_req;
    logic              switch_done;
    logic              out_level;

    modport src (output base_tick, output base_level);
    modport gen (input base_tick, input base_level, input run,
                 input div_val, input trim_val, input switch_req,
                 output switch_done, output out_level);
    modport ctl (input out_level, input switch_done, output run,
                 output div_val, output trim_val, output switch_req);
endinterface : rcod_div_if
`default_nettype wire

// file: core/rcod_src_select.sv
// base clock selection and rising edge detection
`default_nettype none
module rcod_src_select (
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    input  wire logic [3:0] sel_in,
    input  wire logic       peripheral_clock_in,
    input  wire logic       primary_osc_in,
    input  wire logic       fast_rc_oscillator_in,
    input  wire logic       low_power_rc_oscillator_in,
    input  wire logic       secondary_oscillator_in,
    input  wire logic       pll_8x_in,
    input  wire logic       external_reference_input_in,
    rcod_div_if.src         bus
);

    logic sys_toggle_reg;
    logic prev_reg;
    logic level;

    ////////////////////////////////////////////////////////////////////////
    // source mux, reserved codes give no clock
    always_comb begin
        unique case (rcod_pkg::rcod_src_t'(sel_in))
            rcod_pkg::RCOD_SRC_SYS:     level = sys_toggle_reg;
            rcod_pkg::RCOD_SRC_PERIPH:  level = peripheral_clock_in;
            rcod_pkg::RCOD_SRC_PRIMARY: level = primary_osc_in;
            rcod_pkg::RCOD_SRC_FRC:     level = fast_rc_oscillator_in;
            rcod_pkg::RCOD_SRC_LOW_POWER_RC_OSCILLATOR:    level = low_power_rc_oscillator_in;
            rcod_pkg::RCOD_SRC_SECONDARY_OSCILLATOR:    level = secondary_oscillator_in;
            rcod_pkg::RCOD_SRC_PLL8:    level = pll_8x_in;
            rcod_pkg::RCOD_SRC_EXT:     level = external_reference_input_in;
            default:                    level = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sys_toggle_reg <= 1'b0;
            prev_reg       <= 1'b0;
        end else begin
            sys_toggle_reg <= ~sys_toggle_reg;
            prev_reg       <= level;
        end
    end

    assign bus.base_level = level;
    assign bus.base_tick  = level & ~prev_reg;

endmodule : rcod_src_select
`default_nettype wire

// file: core/rcod_div_gen.sv
// fractional half-period divider core
`default_nettype none
module rcod_div_gen #(
    parameter int DIV_W  = 15,
    parameter int TRIM_W = 9
) (
    input  wire logic clk_sys_in,
    input  wire logic reset_in,
    rcod_div_if.gen   bus
);

    logic              out_reg;
    logic [DIV_W:0]    cnt_reg;
    logic [TRIM_W-1:0] frac_reg;
    logic [DIV_W-1:0]  div_act_reg;
    logic [TRIM_W-1:0] trim_act_reg;

    logic              go;
    logic              last;
    logic              apply;
    logic [DIV_W-1:0]  div_use;
    logic [TRIM_W-1:0] trim_use;
    logic              bypass;
    logic [TRIM_W:0]   frac_sum;
    logic [DIV_W:0]    half_len;

    ////////////////////////////////////////////////////////////////////////
    // keep running until the output is back low, so stops never glitch
    assign go       = bus.run | out_reg;
    assign last     = (cnt_reg <= {{DIV_W{1'b0}}, 1'b1});
    assign apply    = bus.switch_req
                    & (~go | (bus.base_tick & (last | ~|div_act_reg)));
    assign div_use  = apply ? bus.div_val : div_act_reg;
    assign trim_use = apply ? bus.trim_val : trim_act_reg;
    assign bypass   = ~|div_use;
    assign frac_sum = {1'b0, frac_reg} + {1'b0, trim_use};
    assign half_len = {1'b0, div_use}
                    + {{DIV_W{1'b0}}, frac_sum[TRIM_W]};

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            div_act_reg  <= '0;
            trim_act_reg <= '0;
        end else if (apply) begin
            div_act_reg  <= bus.div_val;
            trim_act_reg <= bus.trim_val;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            out_reg  <= 1'b0;
            cnt_reg  <= '0;
            frac_reg <= '0;
        end else if (~go) begin
            out_reg  <= 1'b0;
            cnt_reg  <= '0;
            frac_reg <= '0;
        end else if (bypass) begin
            out_reg  <= bus.base_level;
            cnt_reg  <= '0;
            frac_reg <= '0;
        end else if (bus.base_tick) begin
            if (last | apply) begin
                out_reg  <= ~out_reg;
                cnt_reg  <= half_len;
                frac_reg <= frac_sum[TRIM_W-1:0];
            end else begin
                cnt_reg <= cnt_reg - {{DIV_W{1'b0}}, 1'b1};
            end
        end
    end

    assign bus.switch_done = apply;
    assign bus.out_level   = out_reg;

endmodule : rcod_div_gen
`default_nettype wire

// file: core/rcod_refclk_div.sv
// reference clock output divider: register slave, control and pin
//
// Summary of operation
// - the generator runs only while the module enable bit is set; here it runs on after the clear until the output is back low.
// - the pin carries the clock only while the pin output enable is set.
// - with stop-in-idle set the clock halts in Idle, else it keeps running.
// - with run-in-sleep set the clock runs in Sleep, else it stops there.
// - a 4-bit select picks the base clock; reserved codes give none.
// - a nonzero divisor N gives the base clock divided by 2N.
// - a zero divisor passes the base clock through and ignores the trim.
// - the period is twice the divisor plus trim, in base clocks.
// - the 9-bit trim is a fraction of 512 added to each half-period.
// - setting the switch bit loads divisor and trim; hardware clears it.
// - request active is set while the request is on, cleared after off.
// - the source changes only while request active is 0, without glitch.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`default_nettype none
`include "rcod_consts.svh"
module rcod_refclk_div #(
    parameter int ADDR_W = 8,
    parameter int DIV_W  = 15,
    parameter int TRIM_W = 9
) (
    input  wire logic              clk_sys_in,
    input  wire logic              reset_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    input  wire logic              idle_mode_in,
    input  wire logic              sleep_mode_in,
    input  wire logic              peripheral_clock_in,
    input  wire logic              primary_osc_in,
    input  wire logic              fast_rc_oscillator_in,
    input  wire logic              low_power_rc_oscillator_in,
    input  wire logic              secondary_oscillator_in,
    input  wire logic              pll_8x_in,
    input  wire logic              external_reference_input_in,
    output logic                   reference_output_pin_out
);

    ////////////////////////////////////////////////////////////////////////
    // control state
    logic              en_reg;
    logic              sidl_reg;
    logic              out_en_reg;
    logic              slp_reg;
    logic              swen_reg;
    logic              active_reg;
    logic [3:0]        sel_reg;
    logic [3:0]        eff_sel_reg;
    logic [DIV_W-1:0]  div_reg;
    logic [TRIM_W-1:0] trim_reg;
    logic              pin_reg;

    // bus state
    logic              aw_hold_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic              w_hold_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    rcod_div_if #(.DIV_W(DIV_W), .TRIM_W(TRIM_W)) div_bus ();

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks
    rcod_src_select u_src (
        .clk_sys_in                 (clk_sys_in),
        .reset_in                   (reset_in),
        .sel_in                     (eff_sel_reg),
        .peripheral_clock_in        (peripheral_clock_in),
        .primary_osc_in             (primary_osc_in),
        .fast_rc_oscillator_in      (fast_rc_oscillator_in),
        .low_power_rc_oscillator_in (low_power_rc_oscillator_in),
        .secondary_oscillator_in    (secondary_oscillator_in),
        .pll_8x_in                  (pll_8x_in),
        .external_reference_input_in(external_reference_input_in),
        .bus                        (div_bus.src)
    );

    rcod_div_gen #(.DIV_W(DIV_W), .TRIM_W(TRIM_W)) u_gen (
        .clk_sys_in(clk_sys_in),
        .reset_in  (reset_in),
        .bus       (div_bus.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    // run gating by power modes
    logic idle_stop;
    logic sleep_stop;

    assign idle_stop  = idle_mode_in & sidl_reg;
    assign sleep_stop = sleep_mode_in & ~slp_reg;
    assign div_bus.run = active_reg & en_reg & ~idle_stop
                       & ~sleep_stop;
    assign div_bus.div_val    = div_reg;
    assign div_bus.trim_val   = trim_reg;
    assign div_bus.switch_req = swen_reg;

    ////////////////////////////////////////////////////////////////////////
    // write channel decode
    logic [15:0] ctrl_val;
    logic [15:0] div_reg_val;
    logic [15:0] trim_reg_val;
    logic        do_write;
    logic [15:0] wr_old;
    logic [15:0] wr_val;
    logic        wr_ctrl;
    logic        wr_div;
    logic        wr_trim;
    logic        wr_hit;
    logic [7:0]  wr_word;

    assign s_axi_awready_out = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready_out  = ~w_hold_reg & ~bvalid_reg;
    assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_word  = 8'(awaddr_reg) & 8'hFC;
    assign wr_ctrl  = do_write & (wr_word == `RCOD_OFS_CTRL);
    assign wr_div   = do_write & (wr_word == `RCOD_OFS_DIV);
    assign wr_trim  = do_write & (wr_word == `RCOD_OFS_TRIM);
    assign wr_hit   = (wr_word == `RCOD_OFS_CTRL)
                    | (wr_word == `RCOD_OFS_DIV)
                    | (wr_word == `RCOD_OFS_TRIM);
    assign wr_old   = (wr_word == `RCOD_OFS_DIV)  ? div_reg_val
                    : (wr_word == `RCOD_OFS_TRIM) ? trim_reg_val
                    : ctrl_val;
    assign wr_val   = {wstrb_reg[1] ? wdata_reg[15:8] : wr_old[15:8],
                       wstrb_reg[0] ? wdata_reg[7:0]  : wr_old[7:0]};

    ////////////////////////////////////////////////////////////////////////
    // register read views
    assign ctrl_val = {en_reg, 1'b0, sidl_reg, out_en_reg, slp_reg, 1'b0,
                       swen_reg, active_reg, 4'h0, sel_reg};
    assign div_reg_val  = {1'b0, div_reg};
    assign trim_reg_val = {trim_reg, 7'h00};

    ////////////////////////////////////////////////////////////////////////
    // write address and data capture, either order
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (s_axi_awvalid_in & s_axi_awready_out) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_in;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            w_hold_reg <= 1'b0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid_in & s_axi_wready_out) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_in;
            wstrb_reg  <= s_axi_wstrb_in;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `RCOD_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `RCOD_RESP_OKAY : `RCOD_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out  = bresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // read channel
    logic [7:0]  rd_word;
    logic [15:0] rd_val;
    logic        rd_hit;

    assign s_axi_arready_out = ~rvalid_reg;
    assign rd_word = 8'(s_axi_araddr_in) & 8'hFC;
    assign rd_hit  = (rd_word == `RCOD_OFS_CTRL)
                   | (rd_word == `RCOD_OFS_DIV)
                   | (rd_word == `RCOD_OFS_TRIM);
    assign rd_val  = (rd_word == `RCOD_OFS_CTRL) ? ctrl_val
                   : (rd_word == `RCOD_OFS_DIV)  ? div_reg_val
                   : (rd_word == `RCOD_OFS_TRIM) ? trim_reg_val
                   : 16'h0000;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= `RCOD_RESP_OKAY;
        end else if (s_axi_arvalid_in & s_axi_arready_out) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {16'h0000, rd_val};
            rresp_reg  <= rd_hit ? `RCOD_RESP_OKAY : `RCOD_RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out  = rdata_reg;
    assign s_axi_rresp_out  = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            en_reg     <= 1'b0;
            sidl_reg   <= 1'b0;
            out_en_reg <= 1'b0;
            slp_reg    <= 1'b0;
            sel_reg    <= `RCOD_RST_SEL;
        end else if (wr_ctrl) begin
            en_reg     <= wr_val[`RCOD_BIT_EN];
            sidl_reg   <= wr_val[`RCOD_BIT_SIDL];
            out_en_reg <= wr_val[`RCOD_BIT_OUT];
            slp_reg    <= wr_val[`RCOD_BIT_SLP];
            sel_reg    <= wr_val[`RCOD_SEL_MSB:`RCOD_SEL_LSB];
        end
    end

    // switch bit: software set wins over the hardware clear
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            swen_reg <= 1'b0;
        end else if (wr_ctrl & wr_val[`RCOD_BIT_SWEN]) begin
            swen_reg <= 1'b1;
        end else if (div_bus.switch_done) begin
            swen_reg <= 1'b0;
        end
    end

    // divisor and trim staging, applied only through the switch
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            div_reg  <= `RCOD_RST_DIV;
            trim_reg <= `RCOD_RST_TRIM;
        end else begin
            if (wr_div) begin
                div_reg <= wr_val[`RCOD_DIV_MSB:`RCOD_DIV_LSB];
            end
            if (wr_trim) begin
                trim_reg <= wr_val[`RCOD_TRIM_MSB:`RCOD_TRIM_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request active: on with enable, off once the output has come to rest
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            active_reg <= 1'b0;
        end else if (en_reg) begin
            active_reg <= 1'b1;
        end else if (~div_bus.out_level) begin
            active_reg <= 1'b0;
        end
    end

    // source seen by the divider only changes while the request is off
    logic [3:0] sel_next;

    assign sel_next = wr_ctrl ? wr_val[`RCOD_SEL_MSB:`RCOD_SEL_LSB] : sel_reg;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            eff_sel_reg <= `RCOD_RST_SEL;
        end else if (~active_reg & ~en_reg) begin
            eff_sel_reg <= sel_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pin, low whenever request active or pin drive is off
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= out_en_reg & active_reg & div_bus.out_level;
        end
    end

    assign reference_output_pin_out = pin_reg;

endmodule : rcod_refclk_div
`default_nettype wire

// file: test/rcod_base_clocks.sv
// base clock sources of the device clock system
`default_nettype none
module rcod_base_clocks (
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    output logic      [3:0] count_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // every source keeps running, also in sleep
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) count_out <= 4'h0;
        else count_out <= count_out + 4'h1;
    end
endmodule : rcod_base_clocks
`default_nettype wire

// file: test/rcod_refclk_div_properties.sv
// bus and pin assertions of the divider
`default_nettype none
module rcod_refclk_div_props #(parameter int ADDR_W = 8) (
    input wire logic              clk_sys_in,
    input wire logic              reset_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic              s_axi_awvalid_in,
    input wire logic              s_axi_awready_out,
    input wire logic              s_axi_wvalid_in,
    input wire logic              s_axi_wready_out,
    input wire logic [1:0]        s_axi_bresp_out,
    input wire logic              s_axi_bvalid_out,
    input wire logic              s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic              s_axi_arvalid_in,
    input wire logic              s_axi_arready_out,
    input wire logic [31:0]       s_axi_rdata_out,
    input wire logic [1:0]        s_axi_rresp_out,
    input wire logic              s_axi_rvalid_out,
    input wire logic              reference_output_pin_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    sequence s_wr;
        s_axi_awvalid_in && s_axi_awready_out &&
        s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_rd;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    a_wr_unmapped: assert property (s_wr ##0 s_axi_awaddr_in[7:2] > 6'h2
        |-> ##[1:2] s_axi_bvalid_out && s_axi_bresp_out == 2'h2)
        else $error("unmapped write not refused");
    a_wr_mapped: assert property (s_wr ##0 s_axi_awaddr_in[7:2] < 6'h3
        |-> ##[1:2] s_axi_bvalid_out && s_axi_bresp_out == 2'h0)
        else $error("mapped write not answered");
    a_rd_unmapped: assert property (s_rd ##0 s_axi_araddr_in[7:2] > 6'h2
        |=> s_axi_rvalid_out && s_axi_rresp_out == 2'h2 &&
        s_axi_rdata_out == 32'h0) else $error("unmapped read not refused");
    a_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write answer dropped");
    a_busy_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out
        && !s_axi_wready_out) else $error("write taken while answering");
    a_trim_low_zero: assert property (
        s_rd ##0 s_axi_araddr_in[7:2] == 6'h2 |=> s_axi_rdata_out[6:0] == 7'h0)
        else $error("trim low bits not zero");
    a_div_top_zero: assert property (
        s_rd ##0 s_axi_araddr_in[7:2] == 6'h1 |=> !s_axi_rdata_out[15])
        else $error("divisor top bit not zero");
    a_ctrl_reserved: assert property (
        s_rd ##0 s_axi_araddr_in[7:2] == 6'h0 |=> s_axi_rdata_out[7:4] == 4'h0)
        else $error("reserved select bits not zero");
    a_pin_rest_low: assert property ($fell(reset_in)
        |-> !reference_output_pin_out [*3]) else $error("pin not low");
endmodule : rcod_refclk_div_props
bind rcod_refclk_div rcod_refclk_div_props #(.ADDR_W(ADDR_W)) i_props (.*);
`default_nettype wire

// file: test/tb_top.sv
// register-level bench of the reference clock divider
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, awv, wv, br, arv, rr, idl, slp;
    logic        awr, wrd, bv, arr, rv, pin;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, v;
    logic [1:0]  bresp, rresp, lb, lr;
    logic [3:0]  cnt;
    int          miscompares, num_checks;
    localparam logic [3:0] CODES [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                         4'h4, 4'h5, 4'h6, 4'h8};
    localparam int HI [8] = '{1, 2, 4, 8, 8, 4, 2, 8};
    rcod_base_clocks i_rcod_base_clocks (.clk_sys_in(clk), .reset_in(rst),
        .count_out(cnt));
    rcod_refclk_div i_rcod_refclk_div (.clk_sys_in(clk), .reset_in(rst),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .idle_mode_in(idl),
        .sleep_mode_in(slp), .peripheral_clock_in(cnt[1]),
        .primary_osc_in(cnt[2]), .fast_rc_oscillator_in(cnt[3]),
        .low_power_rc_oscillator_in(cnt[3]), .secondary_oscillator_in(cnt[2]),
        .pll_8x_in(cnt[1]), .external_reference_input_in(cnt[3]),
        .reference_output_pin_out(pin));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h0;
        do begin
            @(posedge clk);
            aw = aw | awr;
            w = w | wrd;
            awv <= !aw;
            wv <= !w;
        end while (!(aw && w));
        repeat (2) @(posedge clk);
        br <= 1'h1;
        do @(posedge clk); while (!bv);
        lb = bresp;
    endtask : wr
    task automatic rd(logic [7:0] a);
        ara <= a;
        arv <= 1'h1;
        do @(posedge clk); while (!arr);
        arv <= 1'h0;
        do @(posedge clk); while (!rv);
        v = rdat;
        lr = rresp;
    endtask : rd
    task automatic poll(logic [31:0] m, logic [31:0] e);
        do rd(8'h00); while ((v & m) !== e);
    endtask : poll
    task automatic meas(int eh, int ep);
        int hi, lo;
        hi = 0;
        lo = 0;
        @(negedge clk iff pin === 1'h0);
        @(negedge clk iff pin === 1'h1);
        while (pin === 1'h1) begin @(negedge clk); hi++; end
        while (pin === 1'h0) begin @(negedge clk); lo++; end
        if (eh > 0) chk("high time", eh, hi);
        chk("period", ep, hi + lo);
    endtask : meas
    task automatic quiet;
        int n;
        n = 0;
        repeat (60) @(negedge clk);
        repeat (60) begin @(negedge clk); n += (pin !== 1'h0); end
        chk("pin low", 0, n);
    endtask : quiet
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        {rst, br, rr} = 3'h7;
        {awv, wv, arv, idl, slp, awa, ara, wd} = '0;
        {miscompares, num_checks} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rd(8'h00);
        chk("ctrl reset", 32'h0, v);
        rd(8'h04);
        chk("divisor reset", 32'h0, v);
        rd(8'h08);
        chk("trim reset", 32'h0, v);
        wr(8'h04, 32'hFFFF_FFFF);
        chk("write resp", 32'h0, lb);
        rd(8'h04);
        chk("divisor", 32'h7FFF, v);
        wr(8'h08, 32'hFFFF_FFFF);
        rd(8'h08);
        chk("trim", 32'hFF80, v);
        wr(8'h00, 32'h69F3);
        rd(8'h00);
        chk("ctrl", 32'h2803, v);
        wr(8'h0C, 32'h1);
        chk("unmapped write", 32'h2, lb);
        rd(8'h0C);
        chk("unmapped read", 32'h2, lr);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h200);
        poll(32'h200, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, 32'h9000 | CODES[i]);
            poll(32'h100, 32'h100);
            meas(HI[i], 2 * HI[i]);
            wr(8'h00, {28'h0, CODES[i]});
            poll(32'h100, 32'h0);
        end
        wr(8'h00, 32'h9007);
        quiet;
        wr(8'h00, 32'h7);
        poll(32'h100, 32'h0);
        wr(8'h04, 32'h2);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h203);
        poll(32'h200, 32'h0);
        wr(8'h00, 32'h9003);
        meas(32, 64);
        wr(8'h08, 32'h8000);
        wr(8'h00, 32'h9203);
        poll(32'h200, 32'h0);
        meas(0, 80);
        wr(8'h00, 32'h8003);
        quiet;
        idl <= 1'h1;
        wr(8'h00, 32'hB003);
        quiet;
        wr(8'h00, 32'h9003);
        meas(0, 80);
        idl <= 1'h0;
        slp <= 1'h1;
        quiet;
        wr(8'h00, 32'h9803);
        meas(0, 80);
        slp <= 1'h0;
        wr(8'h00, 32'h3);
        poll(32'h100, 32'h0);
        quiet;
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
